// ==== ics_pkg.sv ====
package ics_pkg;
   // shared timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int RESET_LOW_MIN_WIDTH_NS = 10;
   localparam int RESET_LOW_CYC_INT =
      (RESET_LOW_MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] RESET_LOW_CYC =
      4'((RESET_LOW_CYC_INT < 1) ? 1 : RESET_LOW_CYC_INT);
   localparam int SCL_PERIOD_NS = 2500;
   localparam int SCL_QUARTER_INT = SCL_PERIOD_NS / 4 / CLK_PERIOD_NS;
   localparam logic [7:0] SCL_QUARTER_CYC =
      8'((SCL_QUARTER_INT < 1) ? 1 : SCL_QUARTER_INT);

   // target addressing and the single register
   localparam logic [6:0] DEV_ADDR_BASE = 7'h70;
   localparam logic RW_READ = 1'b1;
   localparam logic [7:0] SEL_RESET = 8'h00;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // controller register map, byte addresses
   localparam logic [7:0] REG_TXDATA = 8'h00;
   localparam logic [7:0] REG_CTRL = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam int CTRL_ADDR_LSB = 0;
   localparam int CTRL_RW_BIT = 8;
   localparam int CTRL_GO_BIT = 9;
   localparam int CTRL_CNT_LSB = 16;
   localparam int STATUS_BUSY_BIT = 0;
   localparam int STATUS_NACK_BIT = 1;
   localparam int STATUS_RX_LSB = 8;

   typedef enum logic [2:0] {
      D_IDLE = 3'h0,
      D_ADDR = 3'h1,
      D_ADDR_ACK = 3'h3,
      D_WR = 3'h2,
      D_WR_ACK = 3'h6,
      D_RD = 3'h7,
      D_RD_ACK = 3'h5,
      D_IGNORE = 3'h4
   } ics_dev_st_e;

   typedef enum logic [2:0] {
      C_IDLE = 3'h0,
      C_START = 3'h1,
      C_ADDR = 3'h3,
      C_WR = 3'h2,
      C_RD = 3'h6,
      C_STOP = 3'h7
   } ics_ctl_st_e;
endpackage

// ==== ics_if.sv ====
`timescale 1ns/1ps
interface ics_if;
   logic ctl_scl_o;
   logic ctl_scl_oe;
   logic ctl_sda_o;
   logic ctl_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic scl;
   logic sda;

   // open-drain wires with pull-ups: low wins
   assign scl = !(ctl_scl_oe && !ctl_scl_o);
   assign sda = !((ctl_sda_oe && !ctl_sda_o) || (dev_sda_oe && !dev_sda_o));

   modport ctl (
      output ctl_scl_o,
      output ctl_scl_oe,
      output ctl_sda_o,
      output ctl_sda_oe,
      input scl,
      input sda
   );

   modport dev (
      output dev_sda_o,
      output dev_sda_oe,
      input scl,
      input sda
   );
endinterface

// ==== ics_dev.sv ====
// Function
// - address lsb: 1 read, 0 write
// - respond at 0x70 plus strap value
// - data follows address, no index byte
// - write: ack address, take bytes until stop
// - any byte count, last byte kept
// - read: ack, shift register out on sda
// - controller releases sda during read bytes
// - keep sending while controller acknowledges
// - nack ends read, release sda
// - bit n enables downstream pair n
// - any pair combination allowed
// - new selection applies only at stop
// - controller stops right after last ack
// - register readable, returns stored selection
// - reset value all zeros
// - low reset pin clears everything
// - power-on reset starts from defaults
// - start only on idle bus
`timescale 1ns/1ps
module ics_dev
   import ics_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic rst_n_i,
   input wire logic addr_strap_bit0_i,
   input wire logic addr_strap_bit1_i,
   input wire logic addr_strap_bit2_i,
   output logic [7:0] pair_en_o,
   ics_if.dev link
);
   typedef struct packed {
      ics_dev_st_e st;
      logic [3:0] bcnt;
      logic [7:0] sh;
      logic rw;
      logic [7:0] sel;
      logic [7:0] pend;
      logic pend_v;
      logic sda_oe;
      logic [1:0] scl_sy;
      logic scl_d;
      logic [1:0] sda_sy;
      logic sda_d;
      logic [1:0] rn_sy;
      logic [2:0] strap_s1;
      logic [2:0] strap_s2;
      logic [3:0] rcnt;
   } ics_dev_s;

   // power-on state: pins assumed released high
   localparam ics_dev_s DEV_RESET = '{
      st: D_IDLE, sel: SEL_RESET, scl_sy: 2'h3, scl_d: 1'b1,
      sda_sy: 2'h3, sda_d: 1'b1, rn_sy: 2'h3, default: '0};

   ics_dev_s dev_reg;
   ics_dev_s dev_next;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic ext_rst;
   logic sda_now;
   logic [6:0] my_addr;

   assign sda_now = dev_reg.sda_sy[1];
   assign scl_rise = dev_reg.scl_sy[1] && !dev_reg.scl_d;
   assign scl_fall = !dev_reg.scl_sy[1] && dev_reg.scl_d;
   assign start_det = dev_reg.scl_sy[1] && dev_reg.scl_d && !sda_now && dev_reg.sda_d;
   assign stop_det = dev_reg.scl_sy[1] && dev_reg.scl_d && sda_now && !dev_reg.sda_d;
   assign ext_rst = (dev_reg.rcnt >= RESET_LOW_CYC);
   assign my_addr = DEV_ADDR_BASE + {4'h0, dev_reg.strap_s2};

   always_comb begin
      dev_next = dev_reg;
      dev_next.scl_sy = {dev_reg.scl_sy[0], link.scl};
      dev_next.scl_d = dev_reg.scl_sy[1];
      dev_next.sda_sy = {dev_reg.sda_sy[0], link.sda};
      dev_next.sda_d = dev_reg.sda_sy[1];
      dev_next.rn_sy = {dev_reg.rn_sy[0], rst_n_i};
      dev_next.strap_s1 = {addr_strap_bit2_i, addr_strap_bit1_i, addr_strap_bit0_i};
      dev_next.strap_s2 = dev_reg.strap_s1;
      // short glitches on the reset pin are filtered out
      if (dev_reg.rn_sy[1]) begin
         dev_next.rcnt = 4'h0;
      end else if (dev_reg.rcnt != 4'hf) begin
         dev_next.rcnt = dev_reg.rcnt + 4'h1;
      end
      if (ext_rst) begin
         dev_next.st = D_IDLE;
         dev_next.bcnt = 4'h0;
         dev_next.sh = 8'h00;
         dev_next.rw = 1'b0;
         dev_next.sel = SEL_RESET;
         dev_next.pend = 8'h00;
         dev_next.pend_v = 1'b0;
         dev_next.sda_oe = 1'b0;
      end else if (stop_det) begin
         dev_next.st = D_IDLE;
         dev_next.sda_oe = 1'b0;
         // only a fully received byte reaches the pairs, and only now
         if (dev_reg.pend_v) begin
            dev_next.sel = dev_reg.pend;
            dev_next.pend_v = 1'b0;
         end
      end else if (start_det) begin
         dev_next.st = D_ADDR;
         dev_next.bcnt = 4'h0;
         dev_next.sda_oe = 1'b0;
      end else begin
         case (dev_reg.st)
            D_ADDR, D_WR: begin
               if (scl_rise) begin
                  dev_next.sh = {dev_reg.sh[6:0], sda_now};
                  dev_next.bcnt = dev_reg.bcnt + 4'h1;
               end else if (scl_fall && dev_reg.bcnt == BITS_PER_BYTE) begin
                  if (dev_reg.st == D_WR) begin
                     dev_next.pend = dev_reg.sh;
                     dev_next.pend_v = 1'b1;
                     dev_next.sda_oe = 1'b1;
                     dev_next.st = D_WR_ACK;
                  end else if (dev_reg.sh[7:1] == my_addr) begin
                     dev_next.rw = dev_reg.sh[0];
                     dev_next.sda_oe = 1'b1;
                     dev_next.st = D_ADDR_ACK;
                  end else begin
                     dev_next.st = D_IGNORE;
                  end
               end
            end
            D_ADDR_ACK: begin
               if (scl_fall) begin
                  dev_next.bcnt = 4'h0;
                  if (dev_reg.rw == RW_READ) begin
                     dev_next.sh = dev_reg.sel;
                     dev_next.sda_oe = !dev_reg.sel[7];
                     dev_next.st = D_RD;
                  end else begin
                     dev_next.sda_oe = 1'b0;
                     dev_next.st = D_WR;
                  end
               end
            end
            D_WR_ACK: begin
               if (scl_fall) begin
                  dev_next.sda_oe = 1'b0;
                  dev_next.bcnt = 4'h0;
                  dev_next.st = D_WR;
               end
            end
            D_RD: begin
               if (scl_rise) begin
                  dev_next.bcnt = dev_reg.bcnt + 4'h1;
               end else if (scl_fall) begin
                  if (dev_reg.bcnt == BITS_PER_BYTE) begin
                     dev_next.sda_oe = 1'b0;
                     dev_next.st = D_RD_ACK;
                  end else begin
                     dev_next.sh = {dev_reg.sh[6:0], 1'b0};
                     dev_next.sda_oe = !dev_reg.sh[6];
                  end
               end
            end
            D_RD_ACK: begin
               if (scl_rise && sda_now) begin
                  dev_next.st = D_IGNORE;
               end else if (scl_fall) begin
                  dev_next.sh = dev_reg.sel;
                  dev_next.sda_oe = !dev_reg.sel[7];
                  dev_next.bcnt = 4'h0;
                  dev_next.st = D_RD;
               end
            end
            D_IDLE, D_IGNORE: begin
               dev_next.sda_oe = 1'b0;
            end
            default: begin
               dev_next.st = D_IDLE;
               dev_next.sda_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dev_reg <= DEV_RESET;
      end else begin
         dev_reg <= dev_next;
      end
   end

   // open drain: the pin is only ever pulled low
   assign link.dev_sda_o = 1'b0;
   assign link.dev_sda_oe = dev_reg.sda_oe;
   assign pair_en_o = dev_reg.sel;
endmodule

// ==== ics_ctl.sv ====
`timescale 1ns/1ps
module ics_ctl
   import ics_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   ics_if.ctl link
);
   typedef struct packed {
      ics_ctl_st_e st;
      logic [1:0] ph;
      logic [7:0] tcnt;
      logic [3:0] bitn;
      logic [7:0] sh;
      logic [3:0] left;
      logic nack;
      logic busy;
      logic scl_oe;
      logic sda_oe;
      logic [6:0] addr;
      logic rw;
      logic [3:0] cnt;
      logic [7:0] txd;
      logic [7:0] rxd;
      logic ack;
      logic [31:0] dat;
      logic [1:0] scl_sy;
      logic [1:0] sda_sy;
   } ics_ctl_s;

   localparam ics_ctl_s CTL_RESET = '{st: C_IDLE, scl_sy: 2'h3, sda_sy: 2'h3, default: '0};

   ics_ctl_s ctl_reg;
   ics_ctl_s ctl_next;
   logic tick;
   logic wb_req;
   logic sending;
   logic byte_end;

   assign tick = ctl_reg.busy && (ctl_reg.tcnt == SCL_QUARTER_CYC - 8'h01);
   assign wb_req = wb_cyc_i && wb_stb_i && !ctl_reg.ack;
   assign sending = (ctl_reg.st == C_ADDR) || (ctl_reg.st == C_WR);
   assign byte_end = (ctl_reg.bitn == BITS_PER_BYTE);

   always_comb begin
      ctl_next = ctl_reg;
      ctl_next.scl_sy = {ctl_reg.scl_sy[0], link.scl};
      ctl_next.sda_sy = {ctl_reg.sda_sy[0], link.sda};
      ctl_next.ack = wb_req;
      // register slave: one wait state, unmapped reads zero
      if (wb_req) begin
         ctl_next.dat = 32'h0000_0000;
         case (wb_adr_i)
            REG_TXDATA: begin
               ctl_next.dat[7:0] = ctl_reg.txd;
               if (wb_we_i && wb_sel_i[0]) begin
                  ctl_next.txd = wb_dat_i[7:0];
               end
            end
            REG_CTRL: begin
               ctl_next.dat[CTRL_ADDR_LSB +: 7] = ctl_reg.addr;
               ctl_next.dat[CTRL_RW_BIT] = ctl_reg.rw;
               ctl_next.dat[CTRL_CNT_LSB +: 4] = ctl_reg.cnt;
               // settings are locked while a transfer runs
               if (wb_we_i && !ctl_reg.busy && wb_sel_i == 4'hf) begin
                  ctl_next.addr = wb_dat_i[CTRL_ADDR_LSB +: 7];
                  ctl_next.rw = wb_dat_i[CTRL_RW_BIT];
                  ctl_next.cnt = wb_dat_i[CTRL_CNT_LSB +: 4];
                  if (wb_dat_i[CTRL_GO_BIT]) begin
                     ctl_next.busy = 1'b1;
                     ctl_next.nack = 1'b0;
                     ctl_next.st = C_START;
                     ctl_next.ph = 2'h0;
                     ctl_next.tcnt = 8'h00;
                     ctl_next.sh = {wb_dat_i[CTRL_ADDR_LSB +: 7], wb_dat_i[CTRL_RW_BIT]};
                     ctl_next.left = (wb_dat_i[CTRL_CNT_LSB +: 4] == 4'h0) ? 4'h0 :
                        wb_dat_i[CTRL_CNT_LSB +: 4] - 4'h1;
                  end
               end
            end
            REG_STATUS: begin
               ctl_next.dat[STATUS_BUSY_BIT] = ctl_reg.busy;
               ctl_next.dat[STATUS_NACK_BIT] = ctl_reg.nack;
               ctl_next.dat[STATUS_RX_LSB +: 8] = ctl_reg.rxd;
            end
            default: begin
               ctl_next.dat = 32'h0000_0000;
            end
         endcase
      end
      if (ctl_reg.busy) begin
         ctl_next.tcnt = tick ? 8'h00 : ctl_reg.tcnt + 8'h01;
      end
      if (tick) begin
         ctl_next.ph = ctl_reg.ph + 2'h1;
         case (ctl_reg.st)
            C_START: begin
               case (ctl_reg.ph)
                  2'h0: begin
                     if (ctl_reg.scl_sy[1] && ctl_reg.sda_sy[1]) begin
                        ctl_next.sda_oe = 1'b1;
                     end else begin
                        ctl_next.ph = 2'h0;
                     end
                  end
                  2'h2: ctl_next.scl_oe = 1'b1;
                  2'h3: begin
                     ctl_next.st = C_ADDR;
                     ctl_next.bitn = 4'h0;
                  end
                  default: ctl_next.ph = ctl_reg.ph + 2'h1;
               endcase
            end
            C_ADDR, C_WR, C_RD: begin
               case (ctl_reg.ph)
                  2'h0: begin
                     if (sending) begin
                        ctl_next.sda_oe = !byte_end && !ctl_reg.sh[7];
                     end else begin
                        // release data bits, ack only if more wanted
                        ctl_next.sda_oe = byte_end && (ctl_reg.left != 4'h0);
                     end
                  end
                  2'h1: ctl_next.scl_oe = 1'b0;
                  2'h2: begin
                     if (sending && byte_end) begin
                        ctl_next.nack = ctl_reg.nack | ctl_reg.sda_sy[1];
                     end else if (!sending && !byte_end) begin
                        ctl_next.sh = {ctl_reg.sh[6:0], ctl_reg.sda_sy[1]};
                     end
                  end
                  default: begin
                     ctl_next.scl_oe = 1'b1;
                     ctl_next.bitn = ctl_reg.bitn + 4'h1;
                     if (sending && !byte_end) begin
                        ctl_next.sh = {ctl_reg.sh[6:0], 1'b0};
                     end
                     if (byte_end) begin
                        ctl_next.bitn = 4'h0;
                        if (ctl_reg.st == C_RD) begin
                           ctl_next.rxd = ctl_reg.sh;
                        end
                        if (ctl_reg.nack || (ctl_reg.st != C_ADDR && ctl_reg.left == 4'h0)) begin
                           ctl_next.st = C_STOP;
                        end else if (ctl_reg.st == C_ADDR) begin
                           ctl_next.st = ctl_reg.rw ? C_RD : C_WR;
                           ctl_next.sh = ctl_reg.txd;
                        end else begin
                           ctl_next.left = ctl_reg.left - 4'h1;
                           ctl_next.sh = ctl_reg.txd;
                        end
                     end
                  end
               endcase
            end
            C_STOP: begin
               case (ctl_reg.ph)
                  2'h0: ctl_next.sda_oe = 1'b1;
                  2'h1: ctl_next.scl_oe = 1'b0;
                  2'h2: ctl_next.sda_oe = 1'b0;
                  default: begin
                     ctl_next.st = C_IDLE;
                     ctl_next.busy = 1'b0;
                  end
               endcase
            end
            default: begin
               ctl_next.st = C_IDLE;
               ctl_next.busy = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctl_reg <= CTL_RESET;
      end else begin
         ctl_reg <= ctl_next;
      end
   end

   assign link.ctl_scl_o = 1'b0;
   assign link.ctl_sda_o = 1'b0;
   assign link.ctl_scl_oe = ctl_reg.scl_oe;
   assign link.ctl_sda_oe = ctl_reg.sda_oe;
   assign wb_ack_o = ctl_reg.ack;
   assign wb_dat_o = ctl_reg.dat;
endmodule

// ==== ics_asserts.sv ====
`timescale 1ns/1ps
module ics_asserts (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic rst_n_i,
   input wire logic [7:0] pair_en_o,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic scl,
   input wire logic sda,
   input wire logic ctl_sda_oe,
   input wire logic dev_sda_oe
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // cycles since the last stop; saturates so it never wraps back into the window
   logic [3:0] stop_age_reg;
   logic sda_d_reg;
   always_ff @(posedge clk_i) begin
      sda_d_reg <= sda;
      if (rst_i) begin
         stop_age_reg <= 4'hf;
      end else if (scl && sda && !sda_d_reg) begin
         stop_age_reg <= 4'h0;
      end else if (stop_age_reg != 4'hf) begin
         stop_age_reg <= stop_age_reg + 4'h1;
      end
   end

   a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_answers_req: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("request not answered in one cycle");
   a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without a request");
   a_sel_at_stop: assert property ($changed(pair_en_o) |-> (stop_age_reg < 4'hc) || (pair_en_o == 8'h00))
      else $error("selection changed away from a stop");
   a_por_clears: assert property (disable iff (1'b0) rst_i |=> (pair_en_o == 8'h00) && !dev_sda_oe)
      else $error("power-on reset left state behind");
   a_pin_reset_clears: assert property ((!rst_n_i) [*8] |=> (pair_en_o == 8'h00) && !dev_sda_oe)
      else $error("reset pin did not clear the selection");
   a_dev_drive_scl_low: assert property ($rose(dev_sda_oe) |-> !scl)
      else $error("device took sda while scl high");
   a_dev_release_scl_low: assert property ($fell(dev_sda_oe) |-> !scl)
      else $error("device let go of sda while scl high");
   // both pulling low while scl is low is harmless on open drain; the bit counts at scl high
   a_ctl_lets_go_in_read: assert property ((dev_sda_oe && scl) |-> !ctl_sda_oe)
      else $error("both ends pull sda while scl high");
   a_start_on_idle: assert property (($rose(ctl_sda_oe) && scl) |-> $past(sda) && !dev_sda_oe)
      else $error("start on a busy bus");

   c_sel_update: cover property ($changed(pair_en_o) && pair_en_o != 8'h00);
   c_dev_drives: cover property ($rose(dev_sda_oe));
   c_pin_reset: cover property ((!rst_n_i) [*8]);
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
   $display("ERROR t=%0t got %h exp %h", $time, got, exp); end end
module testbench;
   import ics_pkg::*;
   logic clk_i, rst_i, rst_n_i;
   logic addr_strap_bit0_i, addr_strap_bit1_i, addr_strap_bit2_i;
   logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [7:0] pair_en_o;
   int num_errors, checks_done;

   ics_if link_if ();
   ics_ctl ics_ctl_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .link(link_if));
   ics_dev ics_dev_inst (.clk_i, .rst_i, .rst_n_i, .addr_strap_bit0_i, .addr_strap_bit1_i,
      .addr_strap_bit2_i, .pair_en_o, .link(link_if));
   ics_asserts ics_asserts_inst (.clk_i, .rst_i, .rst_n_i, .pair_en_o, .wb_cyc_i, .wb_stb_i,
      .wb_ack_o, .scl(link_if.scl), .sda(link_if.sda), .ctl_sda_oe(link_if.ctl_sda_oe),
      .dev_sda_oe(link_if.dev_sda_oe));

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   task automatic summarize();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // entered just after a rising edge; leaves one idle cycle behind
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hf;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 100);
      if (n >= 100) begin
         num_errors++;
         summarize();
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic xfer(input logic [6:0] ad, input logic rw, input logic [3:0] cnt);
      wb(1'b1, REG_CTRL, {12'h000, cnt, 6'h00, 1'b1, rw, 1'b0, ad});
   endtask

   // polls busy; the extra cycles cover the stop-to-selection latency
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         wb(1'b0, REG_STATUS, 32'h0);
         n++;
      end while (rd[STATUS_BUSY_BIT] !== 1'b0 && n < 20000);
      if (n >= 20000) begin
         num_errors++;
         summarize();
      end
      repeat (10) @(posedge clk_i);
   endtask

   initial begin
      num_errors = 0;
      checks_done = 0;
      rst_i = 1'b1;
      rst_n_i = 1'b1;
      {addr_strap_bit2_i, addr_strap_bit1_i, addr_strap_bit0_i} = 3'b110;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      `CHK(pair_en_o, SEL_RESET)
      wb(1'b0, 8'h40, 32'h0);
      `CHK(rd, 32'h0000_0000)
      wb(1'b0, REG_STATUS, 32'h0);
      `CHK(rd[1:0], 2'b00)
      // two data bytes, second byte changed while the first is on the wire
      wb(1'b1, REG_TXDATA, 32'h0000_00a5);
      xfer(DEV_ADDR_BASE + 7'h6, 1'b0, 4'h2);
      repeat (int'(SCL_QUARTER_CYC) * 52) @(posedge clk_i);
      `CHK(pair_en_o, 8'h00)
      wb(1'b1, REG_TXDATA, 32'h0000_003c);
      // first byte is complete and pending here, the stop is still ahead
      repeat (int'(SCL_QUARTER_CYC) * 44) @(posedge clk_i);
      `CHK(pair_en_o, 8'h00)
      wait_idle();
      `CHK(rd[STATUS_NACK_BIT], 1'b0)
      `CHK(pair_en_o, 8'h3c)
      // read two bytes: controller acks the first, nacks the second
      xfer(DEV_ADDR_BASE + 7'h6, RW_READ, 4'h2);
      wait_idle();
      `CHK(rd[STATUS_NACK_BIT], 1'b0)
      `CHK(rd[15:8], 8'h3c)
      `CHK(link_if.sda, 1'b1)
      // strap order reversed would answer here
      wb(1'b1, REG_TXDATA, 32'h0000_0000);
      xfer(7'h73, 1'b0, 4'h1);
      wait_idle();
      `CHK(rd[STATUS_NACK_BIT], 1'b1)
      `CHK(pair_en_o, 8'h3c)
      wb(1'b1, REG_TXDATA, 32'h0000_00ff);
      xfer(DEV_ADDR_BASE + 7'h6, 1'b0, 4'h1);
      wait_idle();
      `CHK(pair_en_o, 8'hff)
      rst_n_i <= 1'b0;
      repeat (20) @(posedge clk_i);
      `CHK(pair_en_o, 8'h00)
      rst_n_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      xfer(DEV_ADDR_BASE + 7'h6, RW_READ, 4'h1);
      wait_idle();
      `CHK(rd[STATUS_NACK_BIT], 1'b0)
      `CHK(rd[15:8], SEL_RESET)
      summarize();
   end
endmodule
